// >>> core/uhd_engine.sv
// module: host controller front end with frame timer, root ports and descriptor walker
// ****************************************
// How it works
// - four functional states live in bits 7:6 of the host control register.
// - no start-of-frame or transaction leaves unless the state is running.
// - writing 0x002D makes the interrupt output level triggered, active high.
// - writing 0x0680 to host control selects the running state.
// - running with nothing attached, each port status reads 0x00010100.
// - a connection turns that port status into 0x00010101.
// - writing 0x00000102 enables the connected port, then reads 0x00010103.
// - frame number register advances once per millisecond frame.
// - start-of-frame and descriptor processing run with no driver help.
// - port 1 role from mode and id pins; port 2 always host.
// - in dual role port 2 never joins session request or negotiation.
// - each descriptor opens with an 8-byte header before its payload.
// - aperiodic, interrupt and two isochronous areas hold descriptors.
// - fixed areas place descriptor n at n times (block size plus 8).
// - isochronous descriptors pack back to back, payload rounded to words.
// - an area is ignored until its buffer status bit is set.
// - skip map bit k passes over descriptor k in fixed areas.
// - header status fields are rewritten after every transaction.
// - header byte layout of counts, code, toggle, size, endpoint, address.
// - a finished descriptor has its active bit cleared.
// - completion codes use the fixed four-bit encoding.
// ****************************************
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uhd_engine
  import uhd_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = uhd_pkg::FRAME_CYC,
  parameter int MEM_AW = 10
) (
  input wire logic core_clk, // 100 MHz
  input wire logic srst, // sync reset, active high
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic [1:0] port_connect, // device present per port, async
  input wire logic dual_role_select_pin, // mode pin, async
  input wire logic port_role_id_pin, // id pin, async
  output uhd_pkg::uhd_role_t port1_role, // port 1 function
  output logic [1:0] host_port_mask, // ports carrying host traffic
  output logic [1:0] srp_hnp_port_mask, // ports joining negotiation
  output logic sof_pulse, // start-of-frame request
  output logic [15:0] sof_frame, // frame number sent with it
  output logic txn_valid, // transaction request pulse
  output uhd_pkg::uhd_txn_t txn, // transaction fields
  input wire logic txn_done, // transaction finished pulse
  input wire uhd_pkg::uhd_res_t txn_res, // result with txn_done
  output logic host_irq // interrupt pin level
);
  import uhd_pkg::*;

  localparam int FW = $clog2(FRAME_CYCLES);

  // ****************************************
  // registers
  // ****************************************
  logic [10:0] ctrl_ff;
  logic [31:0] irq_en_ff, rh_a_ff, rh_b_ff;
  logic [5:0] hw_cfg_ff;
  logic [3:0] buf_stat_ff;
  logic [9:0] aper_blk_ff, int_blk_ff;
  logic [31:0] aper_skip_ff, int_skip_ff;
  logic [20:0] area_cfg_ff [4];
  logic [11:0] mem_addr_ff;
  logic [31:0] mem [2**MEM_AW];
  logic [15:0] frame_ff;
  logic [31:0] rdata_ff;

  logic running;
  assign running = (ctrl_ff[FS_LSB+:2] == FSTATE_RUNNING);

  logic wr_mem;
  assign wr_mem = reg_wr && (reg_addr == OFS_MEM_DATA);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_ff <= '0;
      irq_en_ff <= '0;
      hw_cfg_ff <= '0;
      rh_a_ff <= '0;
      rh_b_ff <= '0;
      buf_stat_ff <= '0;
      aper_blk_ff <= '0;
      int_blk_ff <= '0;
      aper_skip_ff <= '0;
      int_skip_ff <= '0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_HOST_CONTROL) begin
        ctrl_ff <= reg_wdata[10:0];
      end else if (reg_addr == OFS_IRQ_ENABLE) begin
        irq_en_ff <= reg_wdata;
      end else if (reg_addr == OFS_HW_CONFIG) begin
        hw_cfg_ff <= reg_wdata[5:0];
      end else if (reg_addr == OFS_RH_DESC_A) begin
        rh_a_ff <= reg_wdata;
      end else if (reg_addr == OFS_RH_DESC_B) begin
        rh_b_ff <= reg_wdata;
      end else if (reg_addr == OFS_BUFFER_STATUS) begin
        buf_stat_ff <= reg_wdata[3:0];
      end else if (reg_addr == OFS_APER_BLK_SIZE) begin
        aper_blk_ff <= reg_wdata[9:0];
      end else if (reg_addr == OFS_INT_BLK_SIZE) begin
        int_blk_ff <= reg_wdata[9:0];
      end else if (reg_addr == OFS_APER_SKIP) begin
        aper_skip_ff <= reg_wdata;
      end else if (reg_addr == OFS_INT_SKIP) begin
        int_skip_ff <= reg_wdata;
      end
    end
  end

  // one config word per area: base byte offset and descriptor count
  for (genvar a = 0; a < 4; a++) begin : g_area
    always_ff @(posedge core_clk) begin
      if (srst) begin
        area_cfg_ff[a] <= '0;
      end else if (reg_wr && reg_addr == OFS_AREA_CFG0 + 8'(4 * a)) begin
        area_cfg_ff[a] <= {reg_wdata[20:16], 4'h0, reg_wdata[11:0]};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_addr_ff <= '0;
    end else if (reg_wr && reg_addr == OFS_MEM_ADDR) begin
      mem_addr_ff <= {reg_wdata[11:2], 2'b00};
    end else if (wr_mem || (reg_rd && reg_addr == OFS_MEM_DATA)) begin
      mem_addr_ff <= mem_addr_ff + 12'h004;
    end
  end

  // ****************************************
  // pin synchronisers and port roles
  // ****************************************
  logic [3:0] pin_meta_ff, pin_sync_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= {port_role_id_pin, dual_role_select_pin, port_connect};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      port1_role <= ROLE_DUAL;
    end else if (!pin_sync_ff[2]) begin
      port1_role <= ROLE_DUAL;
    end else if (!pin_sync_ff[3]) begin
      port1_role <= ROLE_HOST;
    end else begin
      port1_role <= ROLE_PERIPH;
    end
  end

  // port 2 stays internal host; only port 1 may negotiate
  assign srp_hnp_port_mask = {1'b0, port1_role == ROLE_DUAL};

  // ****************************************
  // root port status
  // ****************************************
  logic [1:0] pes_ff, csc_ff, conn_d_ff;
  logic run_d_ff;
  logic [31:0] port_sts [2];
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic wr_p, conn;
    assign conn = pin_sync_ff[p];
    assign wr_p = reg_wr && reg_addr == (p == 0 ? OFS_PORT1_STATUS : OFS_PORT2_STATUS);
    always_ff @(posedge core_clk) begin
      if (srst || !running || !conn) begin
        pes_ff[p] <= 1'b0;
      end else if (wr_p && reg_wdata[PS_ENABLE]) begin
        pes_ff[p] <= 1'b1;
      end else if (wr_p && reg_wdata[PS_CONNECT]) begin
        pes_ff[p] <= 1'b0;
      end
    end
    // power-up or connect change sets, write one clears; set wins
    always_ff @(posedge core_clk) begin
      if (srst) begin
        csc_ff[p] <= 1'b0;
      end else if ((running && !run_d_ff) || (running && conn != conn_d_ff[p])) begin
        csc_ff[p] <= 1'b1;
      end else if (wr_p && reg_wdata[PS_CHANGE]) begin
        csc_ff[p] <= 1'b0;
      end
    end
    always_comb begin
      port_sts[p] = '0;
      port_sts[p][PS_CONNECT] = conn;
      port_sts[p][PS_ENABLE] = pes_ff[p];
      port_sts[p][PS_POWER] = running;
      port_sts[p][PS_CHANGE] = csc_ff[p];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      conn_d_ff <= '0;
      run_d_ff <= 1'b0;
    end else begin
      conn_d_ff <= pin_sync_ff[1:0];
      run_d_ff <= running;
    end
  end

  assign host_port_mask = {pes_ff[1], pes_ff[0] && port1_role != ROLE_PERIPH};

  // ****************************************
  // frame timer
  // ****************************************
  logic [FW-1:0] fcnt_ff;
  logic tick, run_drop;
  // a state write in the tick cycle must not let a late frame start escape
  assign run_drop = reg_wr && (reg_addr == OFS_HOST_CONTROL) && (reg_wdata[FS_LSB+:2] != FSTATE_RUNNING);
  assign tick = running && !run_drop && (fcnt_ff == FW'(FRAME_CYCLES - 1));
  always_ff @(posedge core_clk) begin
    if (srst || !running || tick) begin
      fcnt_ff <= '0;
    end else begin
      fcnt_ff <= fcnt_ff + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frame_ff <= '0;
      sof_pulse <= 1'b0;
      sof_frame <= '0;
    end else begin
      sof_pulse <= tick;
      if (tick) begin
        frame_ff <= frame_ff + 16'h0001;
        sof_frame <= frame_ff + 16'h0001;
      end
    end
  end

  // ****************************************
  // interrupt pin shaping
  // ****************************************
  logic irq_pend_ff, irq_set;
  assign irq_set = tick && irq_en_ff[IRQ_FRAME_BIT];
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_pend_ff <= 1'b0;
    end else if (irq_set) begin
      irq_pend_ff <= 1'b1;
    end else if (reg_rd && reg_addr == OFS_FRAME_NUMBER) begin
      irq_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      host_irq <= 1'b1;
    end else if (!hw_cfg_ff[CFG_PIN_EN]) begin
      host_irq <= !hw_cfg_ff[CFG_ACT_HIGH];
    end else begin
      // edge mode gives one pulse per event, level mode holds until read
      host_irq <= (hw_cfg_ff[CFG_EDGE] ? irq_set : irq_pend_ff) ~^ hw_cfg_ff[CFG_ACT_HIGH];
    end
  end

  // ****************************************
  // descriptor walker
  // ****************************************
  typedef enum logic [2:0] {S_IDLE, S_AREA, S_HDR, S_ISSUE, S_WAIT, S_WB, S_NEXT} uhd_state_t;
  uhd_state_t st_ff;
  logic [1:0] area_ff;
  logic [4:0] idx_ff;
  logic [11:0] off_ff;
  logic [31:0] hdr0_ff, hdr1_ff;
  uhd_res_t res_ff;

  logic [4:0] area_cnt;
  logic [11:0] cur_byte, step;
  logic [MEM_AW-1:0] w0;
  logic fixed_area, skip_hit, last_area;
  assign area_cnt = area_cfg_ff[area_ff][20:16];
  assign cur_byte = area_cfg_ff[area_ff][11:0] + off_ff;
  assign w0 = MEM_AW'(cur_byte[11:2]);
  assign fixed_area = !area_ff[1];
  assign skip_hit = fixed_area && (area_ff[0] ? int_skip_ff[idx_ff] : aper_skip_ff[idx_ff]);
  assign last_area = (area_ff == 2'd3);

  always_comb begin
    if (fixed_area) begin
      step = 12'(area_ff[0] ? int_blk_ff : aper_blk_ff) + HDR_BYTES;
    end else begin
      step = HDR_BYTES + ((12'(hdr1_ff[9:0]) + 12'h003) & 12'hFFC);
    end
  end

  logic wb_go;
  logic [31:0] wb_word;
  assign wb_go = (st_ff == S_WB) && !wr_mem;
  always_comb begin
    wb_word = hdr0_ff;
    wb_word[7:0] = res_ff.count[7:0];
    wb_word[9:8] = res_ff.count[9:8];
    wb_word[H0_TOGGLE] = hdr0_ff[H0_TOGGLE] ^ (res_ff.code == RC_NO_ERROR);
    wb_word[H0_ACTIVE] = 1'b0;
    wb_word[H0_CODE_LSB+:4] = res_ff.code;
  end

  // software writes take the port; the walker waits a cycle
  always_ff @(posedge core_clk) begin
    if (wr_mem) begin
      mem[MEM_AW'(mem_addr_ff[11:2])] <= reg_wdata;
    end else if (wb_go) begin
      mem[w0] <= wb_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || !running) begin
      st_ff <= S_IDLE;
      area_ff <= '0;
      idx_ff <= '0;
      off_ff <= '0;
      hdr0_ff <= '0;
      hdr1_ff <= '0;
      res_ff <= '0;
    end else begin
      case (st_ff)
        S_IDLE: begin
          if (tick) begin
            area_ff <= '0;
            st_ff <= S_AREA;
          end
        end
        S_AREA: begin
          idx_ff <= '0;
          off_ff <= '0;
          if (buf_stat_ff[area_ff] && area_cnt != 5'd0) begin
            st_ff <= S_HDR;
          end else if (last_area) begin
            st_ff <= S_IDLE;
          end else begin
            area_ff <= area_ff + 2'd1;
          end
        end
        S_HDR: begin
          hdr0_ff <= mem[w0];
          hdr1_ff <= mem[w0 + MEM_AW'(1)];
          if (skip_hit || !mem[w0][H0_ACTIVE]) begin
            st_ff <= S_NEXT;
          end else begin
            st_ff <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          st_ff <= S_WAIT;
        end
        S_WAIT: begin
          if (txn_done) begin
            res_ff <= txn_res;
            st_ff <= S_WB;
          end
        end
        S_WB: begin
          if (wb_go) begin
            st_ff <= S_NEXT;
          end
        end
        default: begin
          off_ff <= off_ff + step;
          idx_ff <= idx_ff + 5'd1;
          if (idx_ff + 5'd1 != area_cnt) begin
            st_ff <= S_HDR;
          end else if (last_area) begin
            st_ff <= S_IDLE;
          end else begin
            area_ff <= area_ff + 2'd1;
            st_ff <= S_AREA;
          end
        end
      endcase
    end
  end

  assign txn_valid = (st_ff == S_ISSUE) && running;
  always_comb begin
    txn.area = area_ff;
    txn.token = hdr1_ff[H1_TOKEN_LSB+:2];
    txn.addr = hdr1_ff[H1_ADDR_LSB+:7];
    txn.endp = hdr0_ff[H0_EP_LSB+:4];
    txn.len = hdr1_ff[9:0];
    txn.toggle = hdr0_ff[H0_TOGGLE];
    txn.speed = hdr0_ff[H0_SPEED];
  end

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst || !reg_rd) begin
      rdata_ff <= '0;
    end else if (reg_addr == OFS_HOST_CONTROL) begin
      rdata_ff <= {21'h0, ctrl_ff};
    end else if (reg_addr == OFS_IRQ_ENABLE) begin
      rdata_ff <= irq_en_ff;
    end else if (reg_addr == OFS_HW_CONFIG) begin
      rdata_ff <= {26'h0, hw_cfg_ff};
    end else if (reg_addr == OFS_RH_DESC_A) begin
      rdata_ff <= rh_a_ff;
    end else if (reg_addr == OFS_RH_DESC_B) begin
      rdata_ff <= rh_b_ff;
    end else if (reg_addr == OFS_PORT1_STATUS) begin
      rdata_ff <= port_sts[0];
    end else if (reg_addr == OFS_PORT2_STATUS) begin
      rdata_ff <= port_sts[1];
    end else if (reg_addr == OFS_FRAME_NUMBER) begin
      rdata_ff <= {16'h0, frame_ff};
    end else if (reg_addr == OFS_BUFFER_STATUS) begin
      rdata_ff <= {28'h0, buf_stat_ff};
    end else if (reg_addr == OFS_APER_BLK_SIZE) begin
      rdata_ff <= {22'h0, aper_blk_ff};
    end else if (reg_addr == OFS_INT_BLK_SIZE) begin
      rdata_ff <= {22'h0, int_blk_ff};
    end else if (reg_addr == OFS_APER_SKIP) begin
      rdata_ff <= aper_skip_ff;
    end else if (reg_addr == OFS_INT_SKIP) begin
      rdata_ff <= int_skip_ff;
    end else if (reg_addr >= OFS_AREA_CFG0 && reg_addr < OFS_MEM_ADDR) begin
      rdata_ff <= {11'h0, area_cfg_ff[2'((reg_addr - OFS_AREA_CFG0) >> 2)]};
    end else if (reg_addr == OFS_MEM_ADDR) begin
      rdata_ff <= {20'h0, mem_addr_ff};
    end else if (reg_addr == OFS_MEM_DATA) begin
      rdata_ff <= mem[MEM_AW'(mem_addr_ff[11:2])];
    end else begin
      rdata_ff <= '0;
    end
  end
  assign reg_rdata = rdata_ff;

  // ****************************************
  // checks
  // ****************************************
  a_quiet_unless_run: assert property (@(posedge core_clk) disable iff (srst)
    !running |-> !txn_valid && !sof_pulse ##1 !txn_valid)
    else $error("traffic outside running state");
  a_frame_step: assert property (@(posedge core_clk) disable iff (srst)
    $changed(frame_ff) |-> frame_ff == $past(frame_ff) + 16'h0001 && sof_pulse)
    else $error("frame number did not step by one");
  a_port_idle_val: assert property (@(posedge core_clk) disable iff (srst)
    running && !pin_sync_ff[0] && csc_ff[0] |-> port_sts[0] == PORT_IDLE_VAL)
    else $error("idle port status wrong");
  a_port_conn_val: assert property (@(posedge core_clk) disable iff (srst)
    running && pin_sync_ff[1] && !pes_ff[1] && csc_ff[1] |-> port_sts[1] == PORT_CONN_VAL)
    else $error("connected port status wrong");
  a_port_enable: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr && reg_addr == OFS_PORT1_STATUS && reg_wdata == PORT_ENA_WRITE && running
    && pin_sync_ff[0] && $stable(pin_sync_ff[0]) && csc_ff[0] |=> port_sts[0] == PORT_ENA_VAL)
    else $error("port enable write had no effect");
  a_role_host: assert property (@(posedge core_clk) disable iff (srst)
    pin_sync_ff[2] && !pin_sync_ff[3] |=> port1_role == ROLE_HOST)
    else $error("port 1 role not host");
  a_area_gate: assert property (@(posedge core_clk) disable iff (srst)
    txn_valid |-> buf_stat_ff[txn.area])
    else $error("transaction from inactive area");
  a_skip_pass: assert property (@(posedge core_clk) disable iff (srst)
    st_ff == S_HDR && skip_hit && running |=> st_ff == S_NEXT || !running)
    else $error("skipped descriptor executed");
  a_fixed_offset: assert property (@(posedge core_clk) disable iff (srst)
    st_ff == S_HDR && fixed_area |-> 32'(off_ff) == 32'(idx_ff) * 32'(step))
    else $error("fixed area offset wrong");
  a_active_clear: assert property (@(posedge core_clk) disable iff (srst)
    wb_go && running |=> !mem[$past(w0)][H0_ACTIVE])
    else $error("active bit not cleared");
endmodule
`default_nettype wire

// >>> core/uhd_pkg.sv
// package: register map, field layout, timing and carrier types of the host descriptor engine
package uhd_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_HOST_CONTROL = 8'h00;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] OFS_HW_CONFIG = 8'h08;
  localparam logic [7:0] OFS_RH_DESC_A = 8'h0C;
  localparam logic [7:0] OFS_RH_DESC_B = 8'h10;
  localparam logic [7:0] OFS_PORT1_STATUS = 8'h14;
  localparam logic [7:0] OFS_PORT2_STATUS = 8'h18;
  localparam logic [7:0] OFS_FRAME_NUMBER = 8'h1C;
  localparam logic [7:0] OFS_BUFFER_STATUS = 8'h20;
  localparam logic [7:0] OFS_APER_BLK_SIZE = 8'h24;
  localparam logic [7:0] OFS_INT_BLK_SIZE = 8'h28;
  localparam logic [7:0] OFS_APER_SKIP = 8'h2C;
  localparam logic [7:0] OFS_INT_SKIP = 8'h30;
  localparam logic [7:0] OFS_AREA_CFG0 = 8'h34;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h44;
  localparam logic [7:0] OFS_MEM_DATA = 8'h48;
  // ****************************************
  // fields and values
  // ****************************************
  localparam int FS_LSB = 6;
  localparam logic [1:0] FSTATE_RESET = 2'h0;
  localparam logic [1:0] FSTATE_RESUME = 2'h1;
  localparam logic [1:0] FSTATE_RUNNING = 2'h2;
  localparam logic [1:0] FSTATE_SUSPEND = 2'h3;
  localparam int IRQ_FRAME_BIT = 2;
  localparam int CFG_PIN_EN = 0;
  localparam int CFG_EDGE = 1;
  localparam int CFG_ACT_HIGH = 2;
  localparam int PS_CONNECT = 0;
  localparam int PS_ENABLE = 1;
  localparam int PS_POWER = 8;
  localparam int PS_CHANGE = 16;
  localparam logic [31:0] PORT_IDLE_VAL = 32'h0001_0100;
  localparam logic [31:0] PORT_CONN_VAL = 32'h0001_0101;
  localparam logic [31:0] PORT_ENA_VAL = 32'h0001_0103;
  localparam logic [31:0] PORT_ENA_WRITE = 32'h0000_0102;
  // header word 0 / word 1 field positions
  localparam int H0_ACTIVE = 11;
  localparam int H0_TOGGLE = 10;
  localparam int H0_CODE_LSB = 12;
  localparam int H0_MPS_LSB = 16;
  localparam int H0_SPEED = 26;
  localparam int H0_EP_LSB = 28;
  localparam int H1_TOKEN_LSB = 10;
  localparam int H1_ADDR_LSB = 16;
  localparam logic [11:0] HDR_BYTES = 12'h008;
  localparam logic [3:0] RC_NO_ERROR = 4'h0;
  localparam logic [3:0] RC_CRC = 4'h1;
  localparam logic [3:0] RC_BIT_STUFF = 4'h2;
  localparam logic [3:0] RC_TOGGLE_MISMATCH = 4'h3;
  localparam logic [3:0] RC_STALL = 4'h4;
  localparam logic [3:0] RC_NO_RESPONSE = 4'h5;
  localparam logic [3:0] RC_PID_CHECK = 4'h6;
  localparam logic [3:0] RC_UNEXPECTED_PID = 4'h7;
  localparam logic [3:0] RC_DATA_OVERRUN = 4'h8;
  localparam logic [3:0] RC_DATA_UNDERRUN = 4'h9;
  localparam logic [3:0] RC_BUF_OVERRUN = 4'hC;
  localparam logic [3:0] RC_BUF_UNDERRUN = 4'hD;
  // ****************************************
  // timing
  // ****************************************
  localparam int FRAME_US = 1000;
  localparam int CLK_MHZ = 100;
  localparam int FRAME_CYC = FRAME_US * CLK_MHZ;
  // ****************************************
  // carrier types
  // ****************************************
  typedef enum logic [1:0] {ROLE_DUAL, ROLE_HOST, ROLE_PERIPH} uhd_role_t;
  typedef struct packed {
    logic [1:0] area;
    logic [1:0] token;
    logic [6:0] addr;
    logic [3:0] endp;
    logic [9:0] len;
    logic toggle;
    logic speed;
  } uhd_txn_t;
  typedef struct packed {
    logic [3:0] code;
    logic [9:0] count;
  } uhd_res_t;
endpackage

// >>> verif/testbench.sv
// self-checking bench: bring-up, ports, roles, frames and one descriptor walk
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uhd_pkg::*;
  localparam int FC = 50;
  logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [7:0] reg_addr = '0, dly = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, f0;
  logic [1:0] port_connect = '0, host_port_mask, srp_hnp_port_mask;
  logic dual_role_select_pin = 0, port_role_id_pin = 0, sof_pulse, txn_valid, txn_done, host_irq;
  logic [15:0] sof_frame;
  logic [9:0] cnt;
  logic [3:0] rc;
  logic [63:0] x;
  logic [63:0] rq[$];
  logic [31:0] tq[$];
  uhd_role_t port1_role;
  uhd_txn_t txn;
  uhd_res_t txn_res, rsp = '0;
  int err_count = 0, checks = 0, seed = 28047, sofs = 0;
  // reserved header bits all zero
  logic [31:0] dsc [8] = '{32'h3008_0800, 32'h007F_0408, 32'h0, 32'h0,
    32'h3008_0800, 32'h0015_0408, 32'hA5A5_A5A5, 32'h5A5A_5A5A};
  uhd_engine #(.FRAME_CYCLES(FC)) uhd_engine_inst (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_connect(port_connect),
    .dual_role_select_pin(dual_role_select_pin), .port_role_id_pin(port_role_id_pin), .port1_role(port1_role),
    .host_port_mask(host_port_mask), .srp_hnp_port_mask(srp_hnp_port_mask), .sof_pulse(sof_pulse),
    .sof_frame(sof_frame), .txn_valid(txn_valid), .txn(txn), .txn_done(txn_done), .txn_res(txn_res),
    .host_irq(host_irq));
  uhd_link_model uhd_link_model_inst (.core_clk(core_clk), .txn_valid(txn_valid), .rsp_delay(dly), .rsp(rsp),
    .txn_done(txn_done), .txn_res(txn_res));
  // ******
  // tasks
  // ******
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge core_clk);
    rq.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic wait_on(ref logic s);
    int i;
    for (i = 0; i < 400 && s !== 1'b1; i++) @(posedge core_clk) #1;
    if (i == 400) begin
      err_count++;
      stop_test();
    end
  endtask
  // read data is only valid the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_d) begin
      x = rq.pop_front();
      cmp(x[31:0], reg_rdata & x[63:32]);
    end
    rd_d <= reg_rd;
    if (txn_valid) cmp(tq.size() ? tq.pop_front() : 32'hFFFF_FFFF, 32'(txn));
    if (sof_pulse) sofs <= sofs + 1;
  end
  initial forever #5 core_clk = ~core_clk;
  // ******
  // scenarios
  // ******
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 2; i >= 0; i--) begin
      dual_role_select_pin <= i > 0;
      port_role_id_pin <= i > 1;
      repeat (4) @(posedge core_clk);
      cmp(i, port1_role);
      cmp(32'(i == 0), srp_hnp_port_mask);
    end
    $display("role test done");
    repeat (3 * FC) @(posedge core_clk);
    cmp(0, sofs);
    wr(8'hFC, $random(seed));
    rd(8'hFC, 32'h0);
    wr(OFS_APER_BLK_SIZE, 32'h8);
    wr(OFS_AREA_CFG0, 32'h0002_0000);
    wr(OFS_APER_SKIP, 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h8000_00FD);
    wr(OFS_HW_CONFIG, 32'h0000_002D);
    wr(OFS_RH_DESC_A, 32'h0500_0B02);
    wr(OFS_RH_DESC_B, 32'h0);
    wr(OFS_HOST_CONTROL, 32'h0000_0680);
    rd(OFS_HOST_CONTROL, 32'h0000_0080, 32'h0000_00C0);
    rd(OFS_PORT1_STATUS, PORT_IDLE_VAL);
    rd(OFS_PORT2_STATUS, PORT_IDLE_VAL);
    port_connect <= 2'b11;
    repeat (4) @(posedge core_clk);
    rd(OFS_PORT1_STATUS, PORT_CONN_VAL);
    rd(OFS_PORT2_STATUS, PORT_CONN_VAL);
    wr(OFS_PORT1_STATUS, PORT_ENA_WRITE);
    rd(OFS_PORT1_STATUS, PORT_ENA_VAL);
    cmp(32'h1, 32'(host_port_mask));
    $display("port bring-up done");
    wait_on(sof_pulse);
    f0 = 32'(sof_frame);
    repeat (2) @(posedge core_clk) #1;
    cmp(1, host_irq);
    rd(OFS_FRAME_NUMBER, f0, 32'h0000_FFFF);
    @(posedge core_clk) #1;
    cmp(0, host_irq);
    wait_on(sof_pulse);
    cmp(f0 + 1, 32'(sof_frame));
    $display("frame test done");
    wr(OFS_MEM_ADDR, 32'h0);
    for (int i = 0; i < 8; i++) wr(OFS_MEM_DATA, dsc[i]);
    repeat (2 * FC) @(posedge core_clk);
    cnt = 10'({$random(seed)} % 9);
    dly <= 8'({$random(seed)} % 8);
    rc = 4'({$random(seed)} % 10);
    rsp <= '{code: rc, count: cnt};
    tq.push_back(32'(uhd_txn_t'{area: 0, token: 1, addr: 7'h15, endp: 4'h3, len: 10'h8, toggle: 0, speed: 0}));
    wr(OFS_BUFFER_STATUS, 32'h1);
    wait_on(txn_done);
    repeat (2 * FC) @(posedge core_clk);
    wr(OFS_MEM_ADDR, 32'h10);
    rd(OFS_MEM_DATA, {16'h3008, rc, 1'b0, rc == RC_NO_ERROR, cnt});
    wr(OFS_MEM_ADDR, 32'h0);
    rd(OFS_MEM_DATA, 32'h3008_0800);
    $display("descriptor walk done");
    wr(OFS_HOST_CONTROL, 32'h0000_00C0);
    repeat (2) @(posedge core_clk);
    f0 = 32'(sofs);
    repeat (3 * FC) @(posedge core_clk);
    cmp(f0, 32'(sofs));
    $display("suspend test done");
    repeat (3) @(posedge core_clk);
    stop_test();
  end
endmodule
`default_nettype wire

// >>> verif/uhd_link_model.sv
// link side responder standing in for the attached peripherals
`timescale 1ns/1ps
`default_nettype none
module uhd_link_model
  import uhd_pkg::*;
(
  input wire logic core_clk, // bench clock
  input wire logic txn_valid, // request from engine
  input wire logic [7:0] rsp_delay, // cycles until reply
  input wire uhd_pkg::uhd_res_t rsp, // result to return
  output logic txn_done, // reply pulse
  output uhd_pkg::uhd_res_t txn_res // result, junk outside reply
);
  int wait_n = -1;
  initial txn_done = 1'b0;
  initial txn_res = '0;
  always @(posedge core_clk) begin
    txn_done <= 1'b0;
    // toggles outside a reply so a stale result is never mistaken for a real one
    txn_res <= ~txn_res;
    if (txn_valid) begin
      wait_n <= rsp_delay;
    end else if (wait_n == 0) begin
      txn_done <= 1'b1;
      txn_res <= rsp;
      wait_n <= -1;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
    end
  end
endmodule
`default_nettype wire
